// [prbs_pkg.sv]
// Behaviour
// - Count every event; store record for one
// - Head kept internally; flush deferred
// - Threshold crossing forces head write to memory
// - Cached tail reread on threshold or full
// - Reread tail every store while threshold
// - Interval reload values cached at load
// - Buffer base and size held internally
// - Missed-event count updated in memory block
// - Refresh cache on load or restore
// - Event counters kept internally, never memory
// - No block access starts outside user ring; only leaving idle is gated, so follow-on accesses of a sequence still start
// - Active only in ring 3, not SYSTEM_MANAGEMENT_MODE
// - No lazy save; task-switched flag ignored
// - Threshold interrupt own vector, not shared
// - Restore without saved component gives defaults
// - Saved image layout identical everywhere
// - Empty restore zeroes address, disables profiling
package prbs_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CFG_OFS    = 8'h00;
  localparam logic [7:0] REG_CBADDR_OFS = 8'h04;
  localparam logic [7:0] REG_CMD_OFS    = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_HEAD_OFS   = 8'h10;
  localparam logic [7:0] REG_TAIL_OFS   = 8'h14;
  // Configuration register fields
  localparam int CFG_VEC_LSB = 0;
  localparam int CFG_EVEN_LSB = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CMD_STORE_BIT = 0;
  // Control block offsets
  localparam logic [31:0] CB_BASE_OFS = 32'h0000_0000;
  localparam logic [31:0] CB_SIZE_OFS = 32'h0000_0004;
  localparam logic [31:0] CB_THR_OFS  = 32'h0000_0008;
  localparam logic [31:0] CB_TAIL_OFS = 32'h0000_000C;
  localparam logic [31:0] CB_HEAD_OFS = 32'h0000_0010;
  localparam logic [31:0] CB_MISS_OFS = 32'h0000_0014;
  localparam logic [31:0] CB_INTV_OFS = 32'h0000_0020;
  localparam int CB_FIXED_WORDS = 4;
  // Record size
  localparam logic [31:0] REC_BYTES = 32'h0000_0004;
  localparam logic [31:0] IMG_CBADDR_OFS = 32'h0000_0000;
  localparam logic [31:0] IMG_HEAD_OFS   = 32'h0000_0008;
  localparam logic [31:0] IMG_BASE_OFS   = 32'h0000_0010;
  localparam logic [31:0] IMG_CNT_OFS    = 32'h0000_0028;
  // Restore bit and user ring
  localparam int RESTORE_COMP_BIT = 62;
  localparam logic [1:0] USER_RING = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Memory engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_TAILRD = 3'b010,
    ST_STORE  = 3'b011,
    ST_HEADWR = 3'b100,
    ST_MISSRD = 3'b101,
    ST_MISSWR = 3'b110
  } prbs_state_t;
endpackage

// [prbs_counter_bank.sv]
`timescale 1ns/1ps
module prbs_counter_bank
  import prbs_pkg::*;
#(
  parameter int N = 4,
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         countEn,
  input  wire logic [N-1:0] evHit,
  input  wire logic         reloadWe,
  input  wire logic [7:0]   reloadIdx,
  input  wire logic [W-1:0] reloadVal,
  output logic      [N-1:0] overflow
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gCnt
      logic [W-1:0] interval_r;
      logic [W-1:0] count_r;
      always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
          interval_r <= '0;
        end else if (reloadWe && reloadIdx == 8'(g)) begin
          interval_r <= reloadVal;
        end
      end
      // Counter held here; every hit counts even if no record follows
      always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
          count_r     <= '0;
          overflow[g] <= 1'b0;
        end else if (reloadWe && reloadIdx == 8'(g)) begin
          count_r     <= reloadVal;
          overflow[g] <= 1'b0;
        end else if (countEn && evHit[g]) begin
          overflow[g] <= (count_r == '0);
          count_r     <= (count_r == '0) ? interval_r : count_r - W'(1);
        end else begin
          overflow[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// [prbs_top.sv]
`timescale 1ns/1ps
module prbs_top
  import prbs_pkg::*;
#(
  parameter int NUM_EVENTS = 4,
  parameter int CNT_W      = 32
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Processor mode
  input  wire logic [1:0]            privRing,
  input  wire logic                  smmActive,
  input  wire logic                  hypActive,
  // Retirement events
  input  wire logic                  retireValid,
  input  wire logic [NUM_EVENTS-1:0] retireEvents,
  input  wire logic [23:0]           retireTag,
  // State restore
  input  wire logic                  restoreReq,
  input  wire logic [63:0]           restoreMask,
  input  wire logic [63:0]           restoreBitmap,
  input  wire logic [31:0]           restoreCbAddr,
  input  wire logic [31:0]           restoreHead,
  // Memory port
  output logic                       memReq,
  output logic                       memWe,
  output logic [31:0]                memAddr,
  output logic [31:0]                memWdata,
  input  wire logic                  memAck,
  input  wire logic [31:0]           memRdata,
  // Threshold interrupt, its own line
  output logic                       thrIrq,
  output logic [7:0]                 thrIrqVector
);
  localparam int FETCH_LAST = CB_FIXED_WORDS + NUM_EVENTS - 1;

  prbs_state_t state_r;
  logic [31:0] cfg_r;
  logic [31:0] cbAddr_r;
  logic [31:0] base_r;
  logic [31:0] size_r;
  logic [31:0] thr_r;
  logic [31:0] tail_r;
  logic [31:0] head_r;
  logic [7:0]  fetchIdx_r;
  logic        refreshPend_r;
  logic        flushReq_r;
  logic        pendValid_r;
  logic [7:0]  pendId_r;
  logic [7:0]  awAddr_r;
  logic        awHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHeld_r;
  logic [NUM_EVENTS-1:0] overflow;
  logic        userActive;
  logic        enabled;
  logic        wrFire;
  logic        loadPulse;
  logic        storePulse;
  logic        restoreEmpty;
  logic        restoreFull;
  logic        bankClear;
  logic        reloadWe;
  logic [31:0] nextHead;

  // Byte-lane merge for register writes
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Fill level between head and tail in a ring of given size
  function automatic logic [31:0] fillOf(input logic [31:0] h, input logic [31:0] t,
                                         input logic [31:0] s);
    return (h >= t) ? (h - t) : (s - t + h);
  endfunction

  // Advance by one record, wrap at size
  function automatic logic [31:0] advance(input logic [31:0] h, input logic [31:0] s);
    logic [31:0] n;
    n = h + REC_BYTES;
    return (n >= s) ? 32'h0000_0000 : n;
  endfunction

  // Lowest-numbered overflowing counter wins the record
  function automatic logic [7:0] pickEvent(input logic [NUM_EVENTS-1:0] v);
    logic [7:0] id;
    id = 8'h00;
    for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        id = 8'(i + 1);
      end
    end
    return id;
  endfunction

  // Only ring 3, never in SYSTEM_MANAGEMENT_MODE or hypervisor
  assign userActive = (privRing == USER_RING) && !smmActive && !hypActive;
  assign enabled    = (cbAddr_r != 32'h0000_0000);
  assign wrFire     = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign loadPulse  = wrFire && (awAddr_r == REG_CBADDR_OFS);
  assign storePulse = wrFire && (awAddr_r == REG_CMD_OFS) && wStrb_r[0]
                      && wData_r[CMD_STORE_BIT];
  assign restoreEmpty = restoreReq && restoreMask[RESTORE_COMP_BIT]
                        && !restoreBitmap[RESTORE_COMP_BIT];
  assign restoreFull  = restoreReq && restoreMask[RESTORE_COMP_BIT]
                        && restoreBitmap[RESTORE_COMP_BIT];
  assign bankClear  = restoreEmpty || (loadPulse && mergeStrb(cbAddr_r, wData_r, wStrb_r) == '0);
  assign reloadWe   = (state_r == ST_FETCH) && memReq && memAck
                      && (fetchIdx_r >= 8'(CB_FIXED_WORDS));
  assign nextHead   = advance(head_r, size_r);

  // Counts every hit; at most one record per retirement
  prbs_counter_bank #(
    .N (NUM_EVENTS),
    .W (CNT_W)
  ) uBank (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clear     (bankClear),
    .countEn   (enabled && userActive && retireValid),
    .evHit     (retireEvents & cfg_r[CFG_EVEN_LSB +: NUM_EVENTS]),
    .reloadWe  (reloadWe),
    .reloadIdx (fetchIdx_r - 8'(CB_FIXED_WORDS)),
    .reloadVal (CNT_W'(memRdata)),
    .overflow  (overflow)
  );

  // AXI write capture, address and data in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r <= REG_CMD_OFS && awAddr_r[1:0] == 2'h0) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration register; its vector steers the interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else if (wrFire && awAddr_r == REG_CFG_OFS) begin
      cfg_r <= mergeStrb(cfg_r, wData_r, wStrb_r);
    end
  end

  // Block address: write is a load; restore may replace
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cbAddr_r <= 32'h0000_0000;
    end else if (restoreEmpty) begin
      cbAddr_r <= 32'h0000_0000;
    end else if (restoreFull) begin
      cbAddr_r <= restoreCbAddr;
    end else if (loadPulse) begin
      cbAddr_r <= mergeStrb(cbAddr_r, wData_r, wStrb_r);
    end
  end

  // AXI read path; state registers answer software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CFG_OFS:    s_axi_rdata <= cfg_r;
          REG_CBADDR_OFS: s_axi_rdata <= cbAddr_r;
          REG_CMD_OFS:    s_axi_rdata <= {31'h0000_0000, flushReq_r};
          REG_STATUS_OFS: s_axi_rdata <= {24'h00_0000, pendValid_r, state_r,
                                          userActive, refreshPend_r, 1'b0, enabled};
          REG_HEAD_OFS:   s_axi_rdata <= head_r;
          REG_TAIL_OFS:   s_axi_rdata <= tail_r;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Refresh request; set wins over fetch-done clear, empty restore wins over both
  always_ff @(posedge ref_clk) begin
    if (rst || restoreEmpty) begin
      refreshPend_r <= 1'b0;
    end else if (restoreFull || (loadPulse && mergeStrb(cbAddr_r, wData_r, wStrb_r) != '0)) begin
      refreshPend_r <= 1'b1;
    end else if (state_r == ST_FETCH && memReq && memAck && fetchIdx_r == 8'(FETCH_LAST)) begin
      refreshPend_r <= 1'b0;
    end
  end

  // Pending record; counting goes on meanwhile
  always_ff @(posedge ref_clk) begin
    if (rst || restoreEmpty || !enabled) begin
      pendValid_r <= 1'b0;
      pendId_r    <= 8'h00;
    end else if (memReq && memAck && (state_r == ST_STORE || state_r == ST_MISSWR)) begin
      pendValid_r <= 1'b0;
    end else if (!pendValid_r && overflow != '0) begin
      pendValid_r <= 1'b1;
      pendId_r    <= pickEvent(overflow);
    end
  end

  // Head flush held until a store-instruction, a load or threshold
  always_ff @(posedge ref_clk) begin
    if (rst || restoreEmpty) begin
      flushReq_r <= 1'b0;
    end else if (storePulse || loadPulse) begin
      flushReq_r <= 1'b1;
    end else if (state_r == ST_HEADWR && memReq && memAck) begin
      flushReq_r <= 1'b0;
    end
  end

  // Memory engine; it leaves idle only in the user ring
  always_ff @(posedge ref_clk) begin
    if (rst || restoreReq) begin
      state_r    <= ST_IDLE;
      memReq     <= 1'b0;
      memWe      <= 1'b0;
      memAddr    <= 32'h0000_0000;
      memWdata   <= 32'h0000_0000;
      fetchIdx_r <= 8'h00;
      thrIrq     <= 1'b0;
      if (rst || restoreEmpty) begin
        base_r <= 32'h0000_0000;
        size_r <= 32'h0000_0000;
        thr_r  <= 32'h0000_0000;
        tail_r <= 32'h0000_0000;
        head_r <= 32'h0000_0000;
      end else if (restoreMask[RESTORE_COMP_BIT]) begin
        head_r <= restoreHead & ~(REC_BYTES - 32'h0000_0001);
      end
    end else begin
      thrIrq <= 1'b0;
      if (memReq && memAck) begin
        memReq <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (loadPulse) begin
            head_r <= 32'h0000_0000;
          end else if (enabled && userActive && !memReq) begin
            // Block access started only from the user ring
            if (refreshPend_r) begin
              state_r    <= ST_FETCH;
              fetchIdx_r <= 8'h00;
              memReq     <= 1'b1;
              memWe      <= 1'b0;
              memAddr    <= cbAddr_r + CB_BASE_OFS;
            end else if (flushReq_r) begin
              state_r  <= ST_HEADWR;
              memReq   <= 1'b1;
              memWe    <= 1'b1;
              memAddr  <= cbAddr_r + CB_HEAD_OFS;
              memWdata <= head_r;
            end else if (pendValid_r) begin
              // Reread on every store while threshold or full
              if (nextHead == tail_r || fillOf(head_r, tail_r, size_r) >= thr_r) begin
                state_r <= ST_TAILRD;
                memReq  <= 1'b1;
                memWe   <= 1'b0;
                memAddr <= cbAddr_r + CB_TAIL_OFS;
              end else begin
                state_r  <= ST_STORE;
                memReq   <= 1'b1;
                memWe    <= 1'b1;
                memAddr  <= base_r + head_r;
                memWdata <= {pendId_r, retireTag};
              end
            end
          end
        end
        ST_FETCH: begin
          if (memReq && memAck) begin
            case (fetchIdx_r)
              8'h00:   base_r <= memRdata;
              8'h01:   size_r <= memRdata & ~(REC_BYTES - 32'h0000_0001);
              8'h02:   thr_r  <= memRdata;
              8'h03:   tail_r <= memRdata;
              default: ;
            endcase
            if (fetchIdx_r == 8'(FETCH_LAST)) begin
              state_r <= ST_IDLE;
            end else begin
              fetchIdx_r <= fetchIdx_r + 8'h01;
              memReq     <= 1'b1;
              memAddr    <= (fetchIdx_r + 8'h01 < 8'(CB_FIXED_WORDS)) ?
                            cbAddr_r + {22'h00_0000, fetchIdx_r + 8'h01, 2'h0} :
                            cbAddr_r + CB_INTV_OFS +
                            {22'h00_0000, fetchIdx_r + 8'h01 - 8'(CB_FIXED_WORDS), 2'h0};
            end
          end
        end
        ST_TAILRD: begin
          if (memReq && memAck) begin
            tail_r <= memRdata;
            memReq <= 1'b1;
            memWe  <= 1'b1;
            if (nextHead == memRdata) begin
              state_r <= ST_MISSRD;
              memWe   <= 1'b0;
              memAddr <= cbAddr_r + CB_MISS_OFS;
            end else begin
              state_r  <= ST_STORE;
              memAddr  <= base_r + head_r;
              memWdata <= {pendId_r, retireTag};
            end
          end
        end
        ST_STORE: begin
          if (memReq && memAck) begin
            head_r  <= nextHead;
            state_r <= ST_IDLE;
            if (fillOf(nextHead, tail_r, size_r) >= thr_r &&
                fillOf(head_r, tail_r, size_r) < thr_r) begin
              state_r  <= ST_HEADWR;
              memReq   <= 1'b1;
              memWe    <= 1'b1;
              memAddr  <= cbAddr_r + CB_HEAD_OFS;
              memWdata <= nextHead;
            end
          end
        end
        ST_HEADWR: begin
          if (memReq && memAck) begin
            state_r <= ST_IDLE;
            thrIrq  <= (fillOf(head_r, tail_r, size_r) >= thr_r);
          end
        end
        ST_MISSRD: begin
          if (memReq && memAck) begin
            state_r  <= ST_MISSWR;
            memReq   <= 1'b1;
            memWe    <= 1'b1;
            memWdata <= memRdata + 32'h0000_0001;
          end
        end
        ST_MISSWR: begin
          if (memReq && memAck) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Vector from config; no task-switched input
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thrIrqVector <= 8'h00;
    end else begin
      thrIrqVector <= cfg_r[CFG_VEC_LSB +: 8];
    end
  end
endmodule

// [prbs_properties.sv]
`timescale 1ns/1ps
module prbs_properties
  import prbs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  privRing,
  input wire logic        smmActive,
  input wire logic        hypActive,
  input wire logic        restoreReq,
  input wire logic [63:0] restoreMask,
  input wire logic [63:0] restoreBitmap,
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic        memAck,
  input wire logic        thrIrq
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Restore may abort a request
  a_mem_held:
    assert property (memReq && !memAck && !restoreReq |=> memReq && $stable(memAddr)
      && $stable(memWe) && $stable(memWdata)) else $error("request moved early");
  // Outside user ring an idle engine stays idle
  a_user_only:
    assert property ((privRing != USER_RING || smmActive || hypActive) [*2] ##0 !memReq
      |=> !memReq) else $error("access outside user ring");
  a_irq_pulse:
    assert property (thrIrq |=> !thrIrq) else $error("interrupt too long");
  // Head written before interrupt
  a_irq_flushed:
    assert property (thrIrq |-> $past(memReq && memAck && memWe && memAddr[4:0] == 5'h10))
      else $error("interrupt without head write");
  a_empty_restore:
    assert property (restoreReq && restoreMask[RESTORE_COMP_BIT]
      && !restoreBitmap[RESTORE_COMP_BIT] |=> !memReq [*4]) else $error("access after reset");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  a_read_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule

bind prbs_top prbs_properties prbs_properties_i (
  .ref_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .privRing, .smmActive, .hypActive, .restoreReq,
  .restoreMask, .restoreBitmap, .memReq, .memWe, .memAddr, .memWdata, .memAck, .thrIrq
);

// [prbs_mem_model.sv]
`timescale 1ns/1ps
module prbs_mem_model
  import prbs_pkg::*;
#(
  parameter logic [31:0] CB   = 32'h0000_0040,
  parameter logic [31:0] BASE = 32'h0000_0080,
  parameter logic [31:0] SIZE = 32'h0000_0020
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  ackDelay,
  input  wire logic        thrIrq,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] mem [0:63];
  logic [1:0]  wait_r;
  // control block laid out only before loading
  initial begin
    for (int i = 0; i < 64; i++)
      mem[i] = 32'h0;
    mem[CB[7:2]] = BASE;
    mem[(CB + CB_SIZE_OFS) >> 2] = SIZE;
    mem[(CB + CB_THR_OFS) >> 2] = 32'h0000_0010;
    for (int i = 0; i < 4; i++)
      mem[((CB + CB_INTV_OFS) >> 2) + i] = 32'h0000_0003;
    memRdata = 32'h0;
    memAck = 1'b0;
  end
  // Ack after a random wait; data churns otherwise
  always @(posedge ref_clk) begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    if (rst)
      wait_r <= 2'h0;
    else if (memReq && !memAck && wait_r < ackDelay)
      wait_r <= wait_r + 2'h1;
    else if (memReq && !memAck) begin
      wait_r <= 2'h0;
      memAck <= 1'b1;
      if (memWe)
        mem[memAddr[7:2]] <= memWdata;
      else
        memRdata <= mem[memAddr[7:2]];
    end
    // Handler empties ring to flushed head
    if (thrIrq)
      mem[(CB + CB_TAIL_OFS) >> 2] <= mem[(CB + CB_HEAD_OFS) >> 2];
  end
endmodule

// [prbs_tb.sv]
`timescale 1ns/1ps
module tb
  import prbs_pkg::*;
;
  localparam logic [31:0] CB   = 32'h0000_0040;
  localparam logic [31:0] BASE = 32'h0000_0080;
  localparam logic [31:0] SIZE = 32'h0000_0020;
  logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, smmActive, hypActive, retireValid, restoreReq;
  logic        memReq, memWe, memAck, thrIrq;
  logic [1:0]  privRing, s_axi_bresp, s_axi_rresp, ackDelay;
  logic [3:0]  s_axi_wstrb, retireEvents;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, thrIrqVector;
  logic [23:0] retireTag;
  logic [31:0] s_axi_wdata, s_axi_rdata, restoreCbAddr, restoreHead;
  logic [31:0] memAddr, memWdata, memRdata, expHead;
  logic [63:0] restoreMask, restoreBitmap;
  int          numErrors, checks, cycles, seed;
  prbs_top #(.NUM_EVENTS(4), .CNT_W(32)) prbs_top_i (
    .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .privRing, .smmActive, .hypActive, .retireValid,
    .retireEvents, .retireTag, .restoreReq, .restoreMask, .restoreBitmap, .restoreCbAddr,
    .restoreHead, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata, .thrIrq,
    .thrIrqVector
  );
  prbs_mem_model #(.CB(CB), .BASE(BASE), .SIZE(SIZE)) prbs_mem_model_i (
    .ref_clk, .rst, .memReq, .memWe, .memAddr, .memWdata, .ackDelay, .thrIrq, .memAck,
    .memRdata
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (numErrors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
    @(posedge ref_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, e);
    check(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Random retirements, ring changes
  task automatic run_events(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      retireValid  <= 1'($random(seed));
      retireEvents <= 4'($random(seed));
      retireTag    <= 24'($random(seed));
      privRing     <= ($random(seed) % 8 == 0) ? 2'h0 : USER_RING;
      smmActive    <= ($random(seed) % 16 == 0);
      hypActive    <= ($random(seed) % 16 == 0);
      ackDelay     <= 2'($random(seed));
    end
  endtask
  // Drain in user ring, then park in kernel
  task automatic settle;
    @(posedge ref_clk);
    retireValid <= 1'b0;
    privRing    <= USER_RING;
    smmActive   <= 1'b0;
    hypActive   <= 1'b0;
    repeat (60) @(posedge ref_clk);
    privRing <= 2'h0;
    @(posedge ref_clk);
  endtask
  task automatic flush_check;
    settle();
    axi_wr(REG_CMD_OFS, 32'h0000_0001, RESP_OKAY);
    settle();
    rdchk(REG_HEAD_OFS, expHead, RESP_OKAY);
    check(prbs_mem_model_i.mem[(CB + CB_HEAD_OFS) >> 2], expHead);
  endtask
  // Record address tracks the wrapping head
  always @(posedge ref_clk) begin
    cycles++;
    if (memReq && memAck && memWe && memAddr >= BASE) begin
      check(memAddr, BASE + expHead);
      check(32'(memWdata[31:24] inside {[8'h01:8'h04]}), 32'h1);
      expHead = (expHead + REC_BYTES) % SIZE;
    end
    if (memReq && memAck && memWe && memAddr < BASE)
      check(32'(memAddr inside {CB + CB_HEAD_OFS, CB + CB_MISS_OFS}), 32'h1);
    if (thrIrq)
      check(32'(thrIrqVector), 32'h5A);
    if (cycles == 8000) begin
      numErrors++;
      final_report();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {smmActive, hypActive, retireValid, restoreReq} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, retireTag} = 72'h0;
    {privRing, ackDelay, retireEvents, restoreMask, restoreBitmap} = 136'h0;
    s_axi_wstrb = 4'hF;
    restoreCbAddr = CB;
    restoreHead = 32'h0000_0008;
    seed = 32'hbf495794;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdchk(REG_CFG_OFS, CFG_RESET, RESP_OKAY);
    rdchk(REG_CBADDR_OFS, 32'h0, RESP_OKAY);
    rdchk(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(REG_STATUS_OFS, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(REG_CFG_OFS, 32'h0000_0F5A, RESP_OKAY);
    expHead = 32'h0;
    axi_wr(REG_CBADDR_OFS, CB, RESP_OKAY);
    run_events(400);
    flush_check();
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      restoreReq    <= 1'b1;
      restoreMask   <= (k == 0) ? 64'h0 : 64'h4000_0000_0000_0000;
      restoreBitmap <= (k == 1) ? 64'h0 : 64'h4000_0000_0000_0000;
      @(posedge ref_clk);
      restoreReq <= 1'b0;
      rdchk(REG_CBADDR_OFS, (k == 1) ? 32'h0 : CB, RESP_OKAY);
    end
    rdchk(REG_HEAD_OFS, 32'h0000_0008, RESP_OKAY);
    expHead = 32'h0000_0008;
    run_events(300);
    flush_check();
    final_report();
  end
endmodule
